// >>> logic/ledw_pkg.sv
// Constants and carriers for the LED display write port
package ledw_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DIGITS = 8;
    localparam int unsigned SCAN_RATE_HZ = 390;
    localparam int unsigned DIGIT_SLOT_CYCLES = CLK_HZ / (SCAN_RATE_HZ * DIGITS);
    localparam int unsigned BLANK_MIN_NS = 2000;
    localparam int unsigned BLANK_CYCLES = (BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] RAM_RESET = 8'h00;
    localparam logic BANK_A_IDX = 1'b0;

    typedef struct packed {
        logic input_bit7_point_or_burst;
        logic input_bit6_font;
        logic input_bit5_lookup;
        logic input_bit4_power;
        logic input_bit3_bank;
        logic input_bit2;
        logic input_bit1;
        logic input_bit0;
    } ledw_word_s;

    typedef struct packed {
        logic select;
        ledw_word_s word;
    } ledw_entry_s;

    typedef enum logic {
        scan_blank = 1'b0,
        scan_show = 1'b1
    } ledw_scan_e;

    // Segment order is {g,f,e,d,c,b,a}
    localparam logic [6:0] HEX_FONT [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                                             7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    localparam logic [6:0] CODEB_FONT [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                                               7'h7F, 7'h6F, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
endpackage

// >>> logic/ledw_port.sv
// Write port, display RAM, setup decoding and digit scan of the LED display driver
//
// Behaviour
// [RL1] The host holds the word steady over the write strobe and the word is taken on the strobe's rising edge.
// [RL2] Select high sends the word to the setup word, select low sends it to display RAM.
// [RL3] A RAM word keeps input bits 0 to 7 as data bits 1 to 8, the top bit lighting the point segment.
// [RL4] Power bit high runs the display; low stops the scan and blanks every digit.
// [RL5] Lookup bit high drives segments straight from RAM bits; low decodes characters.
// [RL6] Font bit high decodes the hexadecimal set; low decodes the alternate code set.
// [RL7] Burst bit high announces that sequential data follows; low selects single-digit update.
// [RL8] With burst low, setup bits 0 to 2 give the digit address for single-digit update, bit 0 least significant.
// [RL9] Setup bit 3 picks the RAM bank in decode modes only: high bank A, low bank B.
// [RL10] After a burst setup word the next eight RAM words fill digits one to eight in order.
// [RL11] Digits are scanned one at a time in a repeating cycle, never two together, segments from that digit's word.
`timescale 1ns/10ps

module ledw_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // Pointers wrap by overflow, so DEPTH is a power of two
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready = count != (AW + 1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr = wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mem <= '{default: '0};
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
endmodule

module ledw_port #(
    parameter int unsigned DIGIT_SLOT_CYCLES = ledw_pkg::DIGIT_SLOT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Host write pins, asynchronous
    input wire logic write_strobe,
    input wire logic select,
    input wire ledw_pkg::ledw_word_s input_word,
    // Back-pressure towards the host
    output logic word_ready,
    // Display drive
    output logic [7:0] digit_en,
    output logic [6:0] seg_out,
    output logic point_segment
);
    localparam logic [15:0] BLANK_LEN = 16'(ledw_pkg::BLANK_CYCLES);
    localparam logic [15:0] SHOW_LEN = 16'(DIGIT_SLOT_CYCLES - ledw_pkg::BLANK_CYCLES);

    // Pin synchronisers; strobe idles high so its stages reset high
    logic wr_s1, wr_s2, wr_s3, sel_s1, sel_s2;
    ledw_pkg::ledw_word_s dat_s1, dat_s2;
    logic wr_edge;
    ledw_pkg::ledw_entry_s cap_entry, head;
    logic drain_valid, drain_ready, pop;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_s1 <= 1'b1;
            wr_s2 <= 1'b1;
            wr_s3 <= 1'b1;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            dat_s1 <= '0;
            dat_s2 <= '0;
        end else begin
            wr_s1 <= write_strobe;
            wr_s2 <= wr_s1;
            wr_s3 <= wr_s2;
            sel_s1 <= select;
            sel_s2 <= sel_s1;
            dat_s1 <= input_word;
            dat_s2 <= dat_s1;
        end
    end

    // Word is steady by the strobe's rise, so the second stage already holds it
    assign wr_edge = wr_s2 && !wr_s3; // RL1
    assign cap_entry = '{select: sel_s2, word: dat_s2};

    ledw_fifo #(
        .WIDTH($bits(ledw_pkg::ledw_entry_s)),
        .DEPTH(ledw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(wr_edge),
        .in_ready(word_ready),
        .in_data(cap_entry),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(head)
    );

    // Setup word, burst tracking and display RAM
    ledw_pkg::ledw_word_s setup, next_setup;
    logic burst_active, next_burst;
    logic [2:0] burst_ptr, next_ptr;
    logic [7:0] ram [2][8];
    logic [7:0] next_ram [2][8];
    logic wr_bank, disp_bank;
    logic [2:0] wr_addr;

    assign pop = drain_valid && drain_ready;
    // No-decode mode ignores the bank bit and uses bank A
    assign disp_bank = setup.input_bit5_lookup ? ledw_pkg::BANK_A_IDX : !setup.input_bit3_bank; // RL9
    assign wr_bank = disp_bank;
    assign wr_addr = burst_active ? burst_ptr : {setup.input_bit2, setup.input_bit1, setup.input_bit0}; // RL8 RL10

    always_comb begin
        next_setup = setup;
        next_burst = burst_active;
        next_ptr = burst_ptr;
        next_ram = ram;
        if (pop) begin
            if (head.select) begin
                next_setup = head.word; // RL2
                next_burst = head.word.input_bit7_point_or_burst; // RL7
                next_ptr = 3'h0;
            end else begin
                next_ram[wr_bank][wr_addr] = head.word; // RL3
                if (burst_active) begin
                    next_ptr = burst_ptr + 3'h1; // RL10
                    if (burst_ptr == 3'h7) begin
                        next_burst = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            setup <= ledw_pkg::SETUP_RESET;
            burst_active <= 1'b0;
            burst_ptr <= 3'h0;
            ram <= '{default: ledw_pkg::RAM_RESET};
        end else begin
            setup <= next_setup;
            burst_active <= next_burst;
            burst_ptr <= next_ptr;
            ram <= next_ram;
        end
    end

    // Digit scan
    ledw_pkg::ledw_scan_e scan_st, next_st;
    logic [15:0] scan_cnt, next_cnt;
    logic [2:0] digit_idx, next_idx;
    logic [7:0] next_digit_en;
    logic [6:0] next_seg, shown_seg;
    logic next_point;
    logic [7:0] cur_word;

    assign cur_word = ram[disp_bank][digit_idx];
    assign shown_seg = setup.input_bit5_lookup ? cur_word[6:0] // RL5
        : (setup.input_bit6_font ? ledw_pkg::HEX_FONT[cur_word[3:0]] // RL6
        : ledw_pkg::CODEB_FONT[cur_word[3:0]]);
    // RAM updates wait for a lit slot so a digit is never half rewritten; powered down drains freely
    assign drain_ready = (scan_st == ledw_pkg::scan_show) || !setup.input_bit4_power;

    always_comb begin
        next_st = scan_st;
        next_cnt = scan_cnt + 16'h1;
        next_idx = digit_idx;
        next_digit_en = 8'h00;
        next_seg = 7'h00;
        next_point = 1'b0;
        case (scan_st)
            ledw_pkg::scan_blank: begin
                if (scan_cnt >= BLANK_LEN - 16'h1) begin
                    next_st = ledw_pkg::scan_show;
                    next_cnt = 16'h0;
                end
            end
            ledw_pkg::scan_show: begin
                next_digit_en = 8'h01 << digit_idx; // RL11
                next_seg = shown_seg;
                next_point = cur_word[7]; // RL3
                if (scan_cnt >= SHOW_LEN - 16'h1) begin
                    next_st = ledw_pkg::scan_blank;
                    next_cnt = 16'h0;
                    next_idx = digit_idx + 3'h1; // RL11
                end
            end
            default: begin
                next_st = ledw_pkg::scan_blank;
                next_cnt = 16'h0;
            end
        endcase
        if (!setup.input_bit4_power) begin
            next_st = ledw_pkg::scan_blank; // RL4
            next_cnt = 16'h0;
            next_digit_en = 8'h00;
            next_seg = 7'h00;
            next_point = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scan_st <= ledw_pkg::scan_blank;
            scan_cnt <= 16'h0;
            digit_idx <= 3'h0;
            digit_en <= 8'h00;
            seg_out <= 7'h00;
            point_segment <= 1'b0;
        end else begin
            scan_st <= next_st;
            scan_cnt <= next_cnt;
            digit_idx <= next_idx;
            digit_en <= next_digit_en;
            seg_out <= next_seg;
            point_segment <= next_point;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_rl1;
        wr_s2 && !wr_s3 && word_ready |=> drain_valid;
    endproperty
    a_rl1: assert property (p_rl1) else $error("strobe edge not queued"); // RL1

    property p_rl2;
        pop && head.select |=> setup == $past(head.word);
    endproperty
    a_rl2: assert property (p_rl2) else $error("setup word not loaded"); // RL2

    property p_rl3;
        pop && !head.select |=> ram[$past(wr_bank)][$past(wr_addr)] == $past(head.word);
    endproperty
    a_rl3: assert property (p_rl3) else $error("RAM word not stored"); // RL3

    property p_rl4;
        !setup.input_bit4_power |=> digit_en == 8'h00 && seg_out == 7'h00 && !point_segment;
    endproperty
    a_rl4: assert property (p_rl4) else $error("display lit while powered down"); // RL4

    property p_rl5;
        scan_st == ledw_pkg::scan_show && setup.input_bit4_power && setup.input_bit5_lookup
            |=> seg_out == $past(cur_word[6:0]);
    endproperty
    a_rl5: assert property (p_rl5) else $error("raw segments differ from RAM"); // RL5

    property p_rl6;
        scan_st == ledw_pkg::scan_show && setup.input_bit4_power && !setup.input_bit5_lookup
            && setup.input_bit6_font && cur_word[3:0] == 4'hA |=> seg_out == 7'h77;
    endproperty
    a_rl6: assert property (p_rl6) else $error("hex decode wrong"); // RL6

    property p_rl7;
        pop && head.select && head.word.input_bit7_point_or_burst |=> burst_active && burst_ptr == 3'h0;
    endproperty
    a_rl7: assert property (p_rl7) else $error("burst not armed"); // RL7

    property p_rl8;
        pop && !head.select && !burst_active
            |=> ram[$past(wr_bank)][{$past(setup.input_bit2), $past(setup.input_bit1), $past(setup.input_bit0)}]
                == $past(head.word);
    endproperty
    a_rl8: assert property (p_rl8) else $error("single digit address wrong"); // RL8

    property p_rl9;
        !setup.input_bit5_lookup && setup.input_bit3_bank |-> wr_bank == 1'b0 && disp_bank == 1'b0;
    endproperty
    a_rl9: assert property (p_rl9) else $error("bank A not chosen"); // RL9

    property p_rl10;
        pop && !head.select && burst_active && burst_ptr == 3'h7 |=> !burst_active;
    endproperty
    a_rl10: assert property (p_rl10) else $error("burst did not end after eight words"); // RL10

    property p_rl11;
        $onehot0(digit_en) && (digit_en == 8'h00 || digit_en == (8'h01 << $past(digit_idx)));
    endproperty
    a_rl11: assert property (p_rl11) else $error("digit enables overlap"); // RL11
endmodule

// >>> verification/ledw_host.sv
// Host model that drives the display write pins
`timescale 1ns/10ps

module ledw_host (
    // Clock
    input wire logic ref_clk,
    // Write pins
    output logic write_strobe,
    output logic select,
    output ledw_pkg::ledw_word_s input_word,
    // Room in the port
    input wire logic word_ready
);
    initial begin
        write_strobe = 1'b1;
        select = 1'b0;
        input_word = '0;
    end

    // Three clocks each side of the edge, wider than the two sync stages
    task automatic write(input logic sel, input logic [7:0] w);
        int n;
        @(negedge ref_clk);
        select = sel;
        input_word = w;
        write_strobe = 1'b0;
        repeat (3) @(negedge ref_clk);
        n = 0;
        // A full port drops the edge, so hold off until there is room
        while (word_ready !== 1'b1 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        write_strobe = 1'b1;
        repeat (3) @(negedge ref_clk);
        // Released bus shows no stale value
        select = ~sel;
        input_word = ~w;
    endtask
endmodule

// >>> verification/tb_top.sv
// Testbench for the LED display write port
`timescale 1ns/10ps

module tb_top;
    localparam int unsigned SLOT = 260;
    logic ref_clk, reset, write_strobe, select, word_ready, point_segment;
    ledw_pkg::ledw_word_s input_word;
    logic [7:0] digit_en;
    logic [6:0] seg_out;
    logic [15:0] exp_q[$];
    logic [7:0] ram[2][8];
    logic [7:0] setup;
    logic watch = 1'b0;
    logic off_watch = 1'b0;
    int burst_left = 0;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int lit_cnt = 0;
    logic [7:0] table_sw[6] = '{8'hB8, 8'h5B, 8'h17, 8'h58, 8'hD0, 8'h35};

    ledw_port #(.DIGIT_SLOT_CYCLES(SLOT)) uut (.ref_clk(ref_clk), .reset(reset), .write_strobe(write_strobe),
        .select(select), .input_word(input_word), .word_ready(word_ready), .digit_en(digit_en),
        .seg_out(seg_out), .point_segment(point_segment));
    ledw_host host (.ref_clk(ref_clk), .write_strobe(write_strobe), .select(select),
        .input_word(input_word), .word_ready(word_ready));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        n_compared++;
        if (seen !== expd) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Raw mode always reads bank A
    function automatic logic [15:0] exp_digit(input int i);
        logic [7:0] w;
        logic [6:0] s;
        w = ram[(setup[5] | setup[3]) ? 0 : 1][i];
        s = setup[5] ? w[6:0] : (setup[6] ? ledw_pkg::HEX_FONT[w[3:0]] : ledw_pkg::CODEB_FONT[w[3:0]]);
        return {8'h01 << i, s, w[7]};
    endfunction

    task automatic host_write(input logic sel, input logic [7:0] w);
        int a;
        host.write(sel, w);
        if (sel) begin
            setup = w;
            burst_left = w[7] ? 8 : 0;
        end else begin
            a = (burst_left > 0) ? 8 - burst_left : int'(setup[2:0]);
            ram[(setup[5] | setup[3]) ? 0 : 1][a] = w;
            if (burst_left > 0) burst_left--;
        end
    endtask

    task automatic wait_en(input logic [7:0] v);
        int n;
        n = 0;
        while (digit_en !== v && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // Line up on a whole scan so every queued word has drained first
    task automatic expect_scan();
        for (int i = 0; i < 8; i++) exp_q.push_back(exp_digit(i));
        wait_en(8'h80);
        wait_en(8'h00);
        watch = 1'b1;
        wait_en(8'h80);
        wait_en(8'h00);
        watch = 1'b0;
        check(16'(exp_q.size()), 16'h0000);
        exp_q.delete();
    endtask

    // Second lit cycle, where segments and digit are both settled
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        lit_cnt <= (digit_en == 8'h00) ? 0 : lit_cnt + 1;
        if (!reset) check({15'h0, $onehot0(digit_en)}, 16'h0001);
        if (off_watch) check({digit_en, seg_out, point_segment}, 16'h0000);
        if (watch && lit_cnt == 1 && exp_q.size() > 0) begin
            check({digit_en, seg_out, point_segment}, exp_q.pop_front());
        end
        if (cyc == 90000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        reset = 1'b1;
        setup = ledw_pkg::SETUP_RESET;
        ram = '{default: ledw_pkg::RAM_RESET};
        void'($urandom(32'h4904));
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        check({digit_en, seg_out, point_segment}, 16'h0000);
        check({15'h0, word_ready}, 16'h0001);
        off_watch = 1'b1;
        repeat (300) @(negedge ref_clk);
        off_watch = 1'b0;
        $display("TEST reset done");
        foreach (table_sw[k]) begin
            host_write(1'b1, table_sw[k]);
            repeat (table_sw[k][7] ? 8 : 1) host_write(1'b0, 8'($urandom));
            expect_scan();
        end
        $display("TEST decode done");
        // A blanking gap drains nothing, so four writes inside it fill the queue
        host_write(1'b1, 8'hD8);
        repeat (SLOT) @(negedge ref_clk);
        wait_en(8'h80);
        wait_en(8'h00);
        for (int i = 0; i < 8; i++) begin
            host_write(1'b0, (i == 2) ? {4'($urandom), 4'hA} : 8'($urandom));
            if (i < 4) check({15'h0, word_ready}, {15'h0, i < 3});
        end
        expect_scan();
        $display("TEST queue done");
        host_write(1'b1, 8'h00);
        // The setup word may sit through a blanking gap before it drains
        repeat (SLOT) @(negedge ref_clk);
        off_watch = 1'b1;
        repeat (600) @(negedge ref_clk);
        off_watch = 1'b0;
        $display("TEST power done");
        print_verdict();
    end
endmodule
